//--- design/kse_params.svh
// Purpose: Constants of the fingerprint key store
// Assumes: Included by the package and the design modules
// Notes:   Key code header word is {tag, length, pad, index}
// How it works
// [R1] Root key is fingerprint XOR activation data, 256 bits wide.
// [R2] Enrollment makes activation data once and presents it for external keeping.
// [R3] Wrap accepts keys from 64 to 4096 bits, two to 128 words.
// [R4] Key codes are key words mixed with root; plain keys never stored.
// [R5] Caller hands a key code back to have its key rebuilt.
// [R6] Caller picks a 4-bit index that travels in the code header.
// [R7] Index zero keys go only to the hardware key bus.
// [R8] Nonzero index keys come out on the 32-bit readout port.
// [R9] No other output ever carries key values.
// [R10] Block cipher consumer takes 128, 192 or 256 bit keys.
// [R11] Flash cipher consumer takes 64-bit blocks under 128-bit keys.
// [R12] Hardware key bus reads zero with valid low until a key lands.
`ifndef KSE_PARAMS_SVH
`define KSE_PARAMS_SVH
`define KSE_ROOT_BITS    256
`define KSE_WORD_BITS    32
`define KSE_MIN_WORDS    8'h02
`define KSE_MAX_WORDS    8'h80
`define KSE_HW_KEY_WORDS 8'h08
`define KSE_IDX_ZERO     4'h0
`define KSE_HDR_IDX      3:0
`define KSE_HDR_PAD      7:4
`define KSE_HDR_LEN      15:8
`define KSE_HDR_TAG      31:16
`define KSE_ROOT_TAG     31:16
`define KSE_ROT_HI       63:32
`endif

//--- design/kse_pkg.sv
// Purpose: Types of the fingerprint key store
// Assumes: kse_params.svh holds the widths
// Notes:   Used by kse_key_store and the bench; kse_word_mix does not import it
`default_nettype none
`include "kse_params.svh"
package kse_pkg;
  typedef enum logic [1:0] {
    KSE_OP_ENROLL,
    KSE_OP_START,
    KSE_OP_WRAP,
    KSE_OP_UNWRAP
  } kse_op_t;

  typedef enum logic [1:0] {
    KSE_ST_IDLE,
    KSE_ST_WRAP,
    KSE_ST_HDR,
    KSE_ST_UNWRAP
  } kse_state_t;

  typedef struct packed {
    kse_op_t    op;
    logic [3:0] index;
    logic [7:0] numWords;
  } kse_cmd_t;

  typedef struct packed {
    logic                      valid;
    logic [`KSE_WORD_BITS-1:0] word;
  } kse_in_t;

  typedef struct packed {
    logic                      valid;
    logic                      isKey;
    logic [`KSE_WORD_BITS-1:0] word;
  } kse_out_t;
endpackage : kse_pkg
`default_nettype wire

//--- design/kse_word_mix.sv
// Purpose: Mixes one data word with a rotated root word
// Assumes: Same function wraps and unwraps, being an XOR
// Notes:   Purely combinational; caller registers the result
`timescale 1ns/10ps
`default_nettype none
`include "kse_params.svh"
module kse_word_mix #(
  parameter int WIDTH = `KSE_WORD_BITS
) (
  input  wire logic [WIDTH-1:0] dataWord,
  input  wire logic [WIDTH-1:0] rootWord,
  input  wire logic [4:0]       position,
  output logic      [WIDTH-1:0] mixed
);
  logic [2*WIDTH-1:0] rotWide;

  always_comb begin
    rotWide = {rootWord, rootWord} << position;
    mixed   = dataWord ^ rotWide[2*WIDTH-1:WIDTH];
  end
endmodule : kse_word_mix
`default_nettype wire

//--- design/kse_key_store.sv
// Purpose: Fingerprint key store: root key, key wrap and rebuild
// Assumes: Inputs synchronous to sys_clk; one data word per cycle
// Notes:   Commands only taken while idle; others raise cmdError
`timescale 1ns/10ps
`default_nettype none
`include "kse_params.svh"
module kse_key_store (
  input  wire logic                      sys_clk,
  input  wire logic                      rst,
  input  wire logic                      cmdValid,
  input  wire kse_pkg::kse_cmd_t         cmd,
  input  wire logic [`KSE_ROOT_BITS-1:0] fingerprint,
  input  wire logic [`KSE_ROOT_BITS-1:0] entropy,
  input  wire logic [`KSE_ROOT_BITS-1:0] actDataIn,
  input  wire kse_pkg::kse_in_t          dataIn,
  output logic      [`KSE_ROOT_BITS-1:0] actDataOut,
  output logic                           actDataOutValid,
  output logic                           rootReady,
  output logic                           busy,
  output logic                           cmdError,
  output kse_pkg::kse_out_t              dataOut,
  output logic      [`KSE_ROOT_BITS-1:0] hwKey,
  output logic                           hwKeyValid
);
  import kse_pkg::*;

  kse_state_t                 state_ff, nxt_state;
  logic [`KSE_ROOT_BITS-1:0]  root_ff, nxt_root;
  logic                       rootReady_ff, nxt_rootReady;
  logic [`KSE_ROOT_BITS-1:0]  act_ff, nxt_act;
  logic                       actValid_ff, nxt_actValid;
  logic [3:0]                 idx_ff, nxt_idx;
  logic [7:0]                 len_ff, nxt_len;
  logic [7:0]                 cnt_ff, nxt_cnt;
  kse_out_t                   out_ff, nxt_out;
  logic [`KSE_ROOT_BITS-1:0]  hwAcc_ff, nxt_hwAcc;
  logic [`KSE_ROOT_BITS-1:0]  hwKey_ff, nxt_hwKey;
  logic                       hwKeyValid_ff, nxt_hwKeyValid;
  logic                       err_ff, nxt_err;
  logic                       busy_ff, nxt_busy;

  logic [`KSE_WORD_BITS-1:0]  rootWord;
  logic [`KSE_WORD_BITS-1:0]  mixed;
  logic [`KSE_HDR_LEN]        hdrLen;
  logic                       cmdTake;
  logic                       lastWord;
  logic                       rangeOk;
  logic                       hdrOk;

  // Root word cycles through the eight root words by position
  assign rootWord = root_ff[cnt_ff[2:0] * `KSE_WORD_BITS +: `KSE_WORD_BITS];
  assign cmdTake  = cmdValid && (state_ff == KSE_ST_IDLE);
  assign lastWord = (cnt_ff == len_ff - 8'h01);
  assign rangeOk  = (cmd.numWords >= `KSE_MIN_WORDS) &&
                    (cmd.numWords <= `KSE_MAX_WORDS);
  assign hdrLen   = dataIn.word[`KSE_HDR_LEN];
  // Tag check rejects codes made under another root key
  assign hdrOk    = (dataIn.word[`KSE_HDR_TAG] == root_ff[`KSE_ROOT_TAG]) &&
                    (hdrLen >= `KSE_MIN_WORDS) && (hdrLen <= `KSE_MAX_WORDS) &&
                    ((dataIn.word[`KSE_HDR_IDX] != `KSE_IDX_ZERO) ||
                     (hdrLen <= `KSE_HW_KEY_WORDS));

  kse_word_mix #(
    .WIDTH (`KSE_WORD_BITS)
  ) u_mix (
    .dataWord (dataIn.word),
    .rootWord (rootWord),
    .position (cnt_ff[4:0]),
    .mixed    (mixed)
  );

  always_comb begin
    nxt_state      = state_ff;
    nxt_root       = root_ff;
    nxt_rootReady  = rootReady_ff;
    nxt_act        = act_ff;
    nxt_actValid   = actValid_ff;
    nxt_idx        = idx_ff;
    nxt_len        = len_ff;
    nxt_cnt        = cnt_ff;
    nxt_out        = '0;
    nxt_hwAcc      = hwAcc_ff;
    nxt_hwKey      = hwKey_ff;
    nxt_hwKeyValid = hwKeyValid_ff;
    nxt_err        = cmdValid && !cmdTake;
    unique case (state_ff)
      KSE_ST_IDLE: begin
        if (cmdTake) begin
          unique case (cmd.op)
            KSE_OP_ENROLL: begin
              // Fresh entropy becomes root; only the XOR leaves
              nxt_root      = entropy;                             // [R1]
              nxt_act       = fingerprint ^ entropy;               // [R2]
              nxt_actValid  = 1'b1;                                // [R2]
              nxt_rootReady = 1'b1;
            end
            KSE_OP_START: begin
              nxt_root      = fingerprint ^ actDataIn;             // [R1]
              nxt_rootReady = 1'b1;
            end
            KSE_OP_WRAP: begin
              if (rootReady_ff && rangeOk) begin                   // [R3]
                nxt_idx   = cmd.index;                             // [R6]
                nxt_len   = cmd.numWords;
                nxt_cnt   = 8'h00;
                nxt_state = KSE_ST_WRAP;
                nxt_out.valid                 = 1'b1;
                nxt_out.word[`KSE_HDR_IDX]    = cmd.index;         // [R6]
                nxt_out.word[`KSE_HDR_LEN]    = cmd.numWords;
                nxt_out.word[`KSE_HDR_TAG]    = root_ff[`KSE_ROOT_TAG];
              end else begin
                nxt_err = 1'b1;
              end
            end
            KSE_OP_UNWRAP: begin
              if (rootReady_ff) begin
                nxt_state = KSE_ST_HDR;                            // [R5]
              end else begin
                nxt_err = 1'b1;
              end
            end
          endcase
        end
      end
      KSE_ST_WRAP: begin
        if (dataIn.valid) begin
          // Only the mixed word is kept, never the plain key
          nxt_out.valid = 1'b1;
          nxt_out.word  = mixed;                                   // [R4]
          nxt_cnt       = cnt_ff + 8'h01;
          if (lastWord) begin
            nxt_state = KSE_ST_IDLE;
          end
        end
      end
      KSE_ST_HDR: begin
        if (dataIn.valid) begin
          if (hdrOk) begin
            nxt_idx   = dataIn.word[`KSE_HDR_IDX];                 // [R6]
            nxt_len   = hdrLen;
            nxt_cnt   = 8'h00;
            nxt_hwAcc = '0;
            nxt_state = KSE_ST_UNWRAP;
          end else begin
            nxt_err   = 1'b1;
            nxt_state = KSE_ST_IDLE;
          end
        end
      end
      KSE_ST_UNWRAP: begin
        if (dataIn.valid) begin
          nxt_cnt = cnt_ff + 8'h01;
          if (idx_ff != `KSE_IDX_ZERO) begin
            nxt_out.valid = 1'b1;                                  // [R8]
            nxt_out.isKey = 1'b1;                                  // [R9]
            nxt_out.word  = mixed;
          end else begin
            // Index zero words never reach the readout port
            nxt_hwAcc[cnt_ff[2:0] * `KSE_WORD_BITS +: `KSE_WORD_BITS] =
              mixed;                                               // [R7]
          end
          if (lastWord) begin
            nxt_state = KSE_ST_IDLE;
            if (idx_ff == `KSE_IDX_ZERO) begin
              nxt_hwKey = nxt_hwAcc;                               // [R7]
              nxt_hwKeyValid = 1'b1;                               // [R12]
              nxt_hwAcc = '0;
            end
          end
        end
      end
    endcase
    nxt_busy = (nxt_state != KSE_ST_IDLE);
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_ff      <= KSE_ST_IDLE;
      root_ff       <= '0;
      rootReady_ff  <= 1'b0;
      act_ff        <= '0;
      actValid_ff   <= 1'b0;
      idx_ff        <= `KSE_IDX_ZERO;
      len_ff        <= 8'h00;
      cnt_ff        <= 8'h00;
      out_ff        <= '0;
      hwAcc_ff      <= '0;
      hwKey_ff      <= '0;                                         // [R12]
      hwKeyValid_ff <= 1'b0;
      err_ff        <= 1'b0;
      busy_ff       <= 1'b0;
    end else begin
      state_ff      <= nxt_state;
      root_ff       <= nxt_root;
      rootReady_ff  <= nxt_rootReady;
      act_ff        <= nxt_act;
      actValid_ff   <= nxt_actValid;
      idx_ff        <= nxt_idx;
      len_ff        <= nxt_len;
      cnt_ff        <= nxt_cnt;
      out_ff        <= nxt_out;
      hwAcc_ff      <= nxt_hwAcc;
      hwKey_ff      <= nxt_hwKey;
      hwKeyValid_ff <= nxt_hwKeyValid;
      err_ff        <= nxt_err;
      busy_ff       <= nxt_busy;
    end
  end

  assign actDataOut      = act_ff;
  assign actDataOutValid = actValid_ff;
  assign rootReady       = rootReady_ff;
  assign busy            = busy_ff;
  assign cmdError        = err_ff;
  assign dataOut         = out_ff;
  assign hwKey           = hwKey_ff;
  assign hwKeyValid      = hwKeyValid_ff;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_root_from_start: assert property (        // [R1]
    cmdTake && cmd.op == KSE_OP_START |=>
      rootReady && root_ff == ($past(fingerprint) ^ $past(actDataIn)))
    else $error("root key not rebuilt from fingerprint");
  a_enroll_act_out: assert property (         // [R2]
    cmdTake && cmd.op == KSE_OP_ENROLL |=>
      actDataOutValid && actDataOut == ($past(fingerprint) ^ $past(entropy)))
    else $error("activation data wrong after enroll");
  a_wrap_len_range: assert property (         // [R3]
    state_ff == KSE_ST_WRAP |->
      len_ff >= `KSE_MIN_WORDS && len_ff <= `KSE_MAX_WORDS)
    else $error("wrap length out of range");
  a_code_is_mixed: assert property (          // [R4]
    state_ff == KSE_ST_WRAP && dataIn.valid |=>
      dataOut.valid && !dataOut.isKey && dataOut.word == $past(mixed))
    else $error("key code word not mixed");
  a_header_index: assert property (           // [R6]
    cmdTake && cmd.op == KSE_OP_WRAP && rootReady && rangeOk |=>
      dataOut.valid && dataOut.word[`KSE_HDR_IDX] == $past(cmd.index)
      ##1 state_ff == KSE_ST_WRAP)
    else $error("index missing from key code header");
  a_idx0_no_readout: assert property (        // [R7]
    dataOut.valid && dataOut.isKey |-> idx_ff != `KSE_IDX_ZERO)
    else $error("index zero key on readout port");
  a_nonzero_readout: assert property (        // [R8]
    state_ff == KSE_ST_UNWRAP && dataIn.valid && idx_ff != `KSE_IDX_ZERO
      |=> dataOut.valid && dataOut.isKey)
    else $error("nonzero index key not read out");
  a_key_exposure: assert property (           // [R9]
    dataOut.isKey |-> dataOut.valid && $past(state_ff) == KSE_ST_UNWRAP)
    else $error("key word outside rebuild");
  a_hw_bus_idle: assert property (            // [R12]
    !hwKeyValid |-> hwKey == '0)
    else $error("hardware key bus not zero while invalid");

  c_enroll:    cover property (cmdTake && cmd.op == KSE_OP_ENROLL);
  c_wrap_done: cover property (state_ff == KSE_ST_WRAP ##1
                               state_ff == KSE_ST_IDLE);
  c_hw_key:    cover property ($rose(hwKeyValid));
  c_read_key:  cover property (dataOut.valid && dataOut.isKey);
endmodule : kse_key_store
`default_nettype wire

//--- verification/kse_key_sink.sv
// Purpose: Cipher engines that take keys off the hardware key bus
// Assumes: Key bus word i sits at bits 32i+31:32i
// Notes:   Latches the bus on every cycle that key valid is high
`timescale 1ns/10ps
`default_nettype none
module kse_key_sink (
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic [255:0] hwKey,
  input  wire logic         hwKeyValid,
  output logic      [255:0] blkKey_ff,
  output logic      [127:0] flashKey_ff
);
  // Block cipher sees all words; 128 or 192 bit keys use the low ones
  // Flash cipher only ever uses the low 128 bits
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      blkKey_ff   <= 256'h0;
      flashKey_ff <= 128'h0;
    end else if (hwKeyValid) begin
      blkKey_ff   <= hwKey;
      flashKey_ff <= hwKey[127:0];
    end
  end
endmodule : kse_key_sink
`default_nettype wire

//--- verification/tb_sram_fingerprint_key_store.sv
// Purpose: Self-checking bench of the fingerprint key store
// Assumes: Commands one cycle wide, words sent while busy; the rest of a code is still sent after its header is refused
// Notes:   Expected code words rebuilt from the root the bench tracks
`timescale 1ns/10ps
`default_nettype none
`include "kse_params.svh"
module tb_sram_fingerprint_key_store;
  import kse_pkg::*;
  logic         sys_clk;
  logic         rst;
  logic         cmdValid;
  kse_cmd_t     cmd;
  logic [255:0] fingerprint;
  logic [255:0] entropy;
  logic [255:0] actDataIn;
  kse_in_t      dataIn;
  logic [255:0] actDataOut;
  logic         actDataOutValid;
  logic         rootReady;
  logic         busy;
  logic         cmdError;
  kse_out_t     dataOut;
  logic [255:0] hwKey;
  logic         hwKeyValid;
  logic [127:0] flashKey;
  logic [255:0] blkKey;
  logic [255:0] root;
  logic [255:0] expHw;
  logic         hwSet;
  logic [31:0]  keyQ[$];
  logic [31:0]  codeQ[$];
  logic [31:0]  sendQ[$];
  kse_out_t     outQ[$];
  int           n_errors;
  int           num_checks;
  int           nErr;

  kse_key_store kse_key_store_i (
    .sys_clk(sys_clk), .rst(rst), .cmdValid(cmdValid), .cmd(cmd),
    .fingerprint(fingerprint), .entropy(entropy), .actDataIn(actDataIn),
    .dataIn(dataIn), .actDataOut(actDataOut),
    .actDataOutValid(actDataOutValid), .rootReady(rootReady),
    .busy(busy), .cmdError(cmdError), .dataOut(dataOut),
    .hwKey(hwKey), .hwKeyValid(hwKeyValid));
  kse_key_sink kse_key_sink_i (
    .sys_clk(sys_clk), .rst(rst), .hwKey(hwKey),
    .hwKeyValid(hwKeyValid), .blkKey_ff(blkKey), .flashKey_ff(flashKey));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Pulses stand one cycle; the falling edge sees them settled, once
  always @(negedge sys_clk) begin
    if (dataOut.valid === 1'b1)
      outQ.push_back(dataOut);
    if (cmdError === 1'b1)
      nErr++;
  end

  task chk(string what, logic [255:0] exp, logic [255:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task finish_test();
    $display("Checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test

  function automatic logic [31:0] mix(int i, logic [31:0] w);
    logic [31:0] r;
    r = root[32*(i%8)+:32];
    return w ^ ((r << (i % 32)) | (r >> (32 - i % 32)));
  endfunction : mix

  function automatic logic [255:0] rnd256();
    logic [255:0] v;
    for (int i = 0; i < 8; i++)
      v[32*i+:32] = $urandom;
    return v;
  endfunction : rnd256

  task step();
    @(posedge sys_clk);
    #1;
  endtask : step

  task send_cmd(kse_op_t op, logic [3:0] idx, logic [7:0] n);
    step();
    cmdValid = 1'b1;
    cmd = '{op, idx, n};
    step();
    cmdValid = 1'b0;
    repeat (2) step();
  endtask : send_cmd

  task wait_busy(logic lvl);
    for (int k = 0; k < 40 && busy !== lvl; k++)
      step();
    chk("busy", lvl, busy);
  endtask : wait_busy

  task send_q();
    foreach (sendQ[i]) begin
      dataIn = '{1'b1, sendQ[i]};
      step();
    end
    dataIn.valid = 1'b0;
    wait_busy(1'b0);
    repeat (2) step();
  endtask : send_q

  task do_wrap(logic [3:0] idx, int n, bit clash);
    int e;
    e = nErr;
    keyQ.delete();
    outQ.delete();
    codeQ.delete();
    repeat (n) keyQ.push_back($urandom);
    step();
    cmdValid = 1'b1;
    cmd = '{KSE_OP_WRAP, idx, n[7:0]};
    step();
    // A clash lands while the wrap is already running
    cmdValid = clash;
    step();
    cmdValid = 1'b0;
    wait_busy(1'b1);
    sendQ = keyQ;
    send_q();
    chk("refused", e + clash, nErr);
    chk("code count", n + 1, outQ.size());
    foreach (outQ[i])
      codeQ.push_back(outQ[i].word);
    chk("header", {root[31:16], n[7:0], 4'h0, idx}, codeQ[0]);
    for (int i = 0; i < n; i++)
      chk("code", {1'b0, mix(i, keyQ[i])}, {outQ[i+1].isKey, codeQ[i+1]});
  endtask : do_wrap

  task do_unwrap(logic [3:0] idx, bit bad);
    int e;
    bit rej;
    e = nErr;
    // Index zero keys longer than the key bus are refused at the header
    rej = bad || (idx == 4'h0 && keyQ.size() > 8);
    outQ.delete();
    send_cmd(KSE_OP_UNWRAP, idx, 8'h00);
    sendQ = codeQ;
    if (bad)
      sendQ[0] = ~sendQ[0];
    if (idx == 4'h0 && !rej) begin
      expHw = 256'h0;
      foreach (keyQ[i])
        expHw[32*i+:32] = keyQ[i];
      hwSet = 1'b1;
    end
    send_q();
    chk("header error", e + rej, nErr);
    if (idx == 4'h0 || rej)
      chk("readout count", 0, outQ.size());
    else begin
      chk("readout count", keyQ.size(), outQ.size());
      foreach (outQ[i])
        chk("key word", {1'b1, keyQ[i]}, {outQ[i].isKey, outQ[i].word});
    end
    chk("key bus", expHw, hwKey);
    chk("key valid", hwSet, hwKeyValid);
    chk("flash key", expHw[127:0], flashKey);
    chk("block key", expHw, blkKey);
  endtask : do_unwrap

  initial begin
    void'($urandom(32'h8FE52C17));
    {rst, cmdValid, cmd, dataIn, hwSet} = '0;
    rst = 1'b1;
    {n_errors, num_checks, nErr} = '0;
    {root, expHw, actDataIn} = '0;
    fingerprint = rnd256();
    entropy = rnd256();
    repeat (2) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    chk("key bus at reset", 0, hwKey);
    chk("key valid at reset", 0, hwKeyValid);
    send_cmd(KSE_OP_WRAP, 4'h1, 8'h02);
    chk("wrap without root", 1, nErr);
    send_cmd(KSE_OP_UNWRAP, 4'h1, 8'h00);
    chk("unwrap without root", 2, nErr);
    send_cmd(KSE_OP_ENROLL, 4'h0, 8'h00);
    root = entropy;
    chk("activation", fingerprint ^ entropy, actDataOut);
    chk("enrolled", 2'b11, {actDataOutValid, rootReady});
    send_cmd(KSE_OP_WRAP, 4'h1, 8'h01);
    send_cmd(KSE_OP_WRAP, 4'h1, 8'h81);
    chk("size refusal", 4, nErr);
    do_wrap(4'h3, 2, 1'b0);
    do_unwrap(4'h3, 1'b0);
    do_wrap(4'hF, 128, 1'b1);
    do_unwrap(4'hF, 1'b0);
    for (int k = 0; k < 3; k++) begin
      do_wrap(4'(1 + $urandom % 15), 2 + $urandom % 127, 1'b0);
      do_unwrap(codeQ[0][3:0], 1'b0);
    end
    // Fresh entropy must not disturb a root rebuilt from activation data
    actDataIn = actDataOut;
    entropy = rnd256();
    send_cmd(KSE_OP_START, 4'h0, 8'h00);
    chk("restarted", 1, rootReady);
    do_unwrap(codeQ[0][3:0], 1'b0);
    do_wrap(4'h0, 4, 1'b0);
    do_unwrap(4'h0, 1'b0);
    do_unwrap(4'h0, 1'b1);
    do_wrap(4'h0, 8, 1'b0);
    do_unwrap(4'h0, 1'b0);
    do_wrap(4'h0, 9, 1'b0);
    do_unwrap(4'h0, 1'b0);
    finish_test();
  end

  initial begin
    repeat (30000) @(posedge sys_clk);
    n_errors++;
    finish_test();
  end
endmodule : tb_sram_fingerprint_key_store
`default_nettype wire
